// ---- logic/drq_pkg.sv ----
// Purpose: Constants for the region access mask and queue view block
// Assumes: 32-bit APB, byte addresses, 12 address bits decoded
// Notes:   Channel register windows are repeated per shadow region

package drq_pkg;

    // ****************************************
    // Widths and counts
    // ****************************************
    localparam int DRQ_AW           = 12;
    localparam int DRQ_DW           = 32;
    localparam int DRQ_DMA_CH       = 32;
    localparam int DRQ_QCK_CH       = 8;
    localparam int DRQ_QUEUES       = 2;
    localparam int DRQ_SLOTS        = 16;
    localparam int DRQ_REGIONS      = 4;

    // ****************************************
    // Address map
    // ****************************************
    // Region masks: base + 8*m, dma mask at +0, quick mask at +4
    localparam logic [11:0] DRQ_MASK_BASE   = 12'h000;
    localparam logic [11:0] DRQ_MASK_STRIDE = 12'h008;
    localparam logic [11:0] DRQ_MASK_QCK    = 12'h004;
    // Global channel register window
    localparam logic [11:0] DRQ_GLB_BASE    = 12'h100;
    // Shadow windows: base + 0x20*m, same layout as the global one
    localparam logic [11:0] DRQ_SHD_BASE    = 12'h200;
    localparam logic [11:0] DRQ_SHD_STRIDE  = 12'h020;
    // Queue entries: base + 0x40*queue + 4*slot
    localparam logic [11:0] DRQ_QUE_BASE    = 12'h400;
    localparam logic [11:0] DRQ_QUE_STRIDE  = 12'h040;
    localparam logic [11:0] DRQ_QUE_TOP     = 12'h480;

    // Word offsets inside a channel register window
    localparam logic [2:0] DRQ_W_CH_EN      = 3'h0;
    localparam logic [2:0] DRQ_W_INT_EN     = 3'h1;
    localparam logic [2:0] DRQ_W_INT_PEND   = 3'h2;
    localparam logic [2:0] DRQ_W_QCK_EN     = 3'h3;
    localparam int         DRQ_WIN_WORDS    = 4;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] DRQ_DMA_MASK_RST = 32'h0000_0000;
    localparam logic [7:0]  DRQ_QCK_MASK_RST = 8'h00;
    localparam logic [31:0] DRQ_CH_RST       = 32'h0000_0000;

    // ****************************************
    // Queue entry fields
    // ****************************************
    localparam int DRQ_KIND_LSB  = 6;
    localparam int DRQ_KIND_W    = 2;
    localparam int DRQ_CHAN_LSB  = 0;
    localparam int DRQ_CHAN_W    = 5;

    typedef enum logic [1:0] {
        DRQ_KIND_HW_LATCH = 2'h0,
        DRQ_KIND_MANUAL   = 2'h1,
        DRQ_KIND_CHAIN    = 2'h2,
        DRQ_KIND_QUICK    = 2'h3
    } drq_kind_t;

endpackage

// ---- logic/drq_queue_store.sv ----
// Purpose: Holds the slots of every event queue for read-only viewing
// Assumes: The queue logic writes one slot per cycle
// Notes:   Contents after reset carry no meaning

`timescale 1ns/1ns

module drq_queue_store
    import drq_pkg::*;
#(
    parameter int QUEUES = DRQ_QUEUES,
    parameter int SLOTS  = DRQ_SLOTS
)
(
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_b_i,
    input  wire logic                       ce_i,
    // Write side
    input  wire logic                       wr_i,
    input  wire logic [$clog2(QUEUES)-1:0]  wr_queue_i,
    input  wire logic [$clog2(SLOTS)-1:0]   wr_slot_i,
    input  wire drq_pkg::drq_kind_t         wr_kind_i,
    input  wire logic [DRQ_CHAN_W-1:0]      wr_chan_i,
    // Read side
    input  wire logic [$clog2(QUEUES)-1:0]  rd_queue_i,
    input  wire logic [$clog2(SLOTS)-1:0]   rd_slot_i,
    output logic [DRQ_DW-1:0]               rd_data_o
);

    import drq_pkg::*;

    initial
    begin
        if (QUEUES < 2 || SLOTS < 2)
            $error("drq_queue_store: need two or more queues and slots");
    end

    typedef struct packed {
        logic [QUEUES-1:0][SLOTS-1:0][DRQ_KIND_W-1:0] kind;
        logic [QUEUES-1:0][SLOTS-1:0][DRQ_CHAN_W-1:0] chan;
    } drq_store_t;

    drq_store_t st_reg;
    drq_store_t st_next;

    always_comb
    begin
        st_next = st_reg;
        if (wr_i)
        begin
            st_next.kind[wr_queue_i][wr_slot_i] = wr_kind_i;
            st_next.chan[wr_queue_i][wr_slot_i] = wr_chan_i;
        end
    end

    // Reset clears the slots only to keep simulation free of unknowns
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            st_reg <= '0;
        else if (ce_i)
            st_reg <= st_next;
    end

    // Bit 5 and the upper bits are held at zero
    always_comb
    begin
        rd_data_o = '0;
        rd_data_o[DRQ_KIND_LSB +: DRQ_KIND_W] =
            st_reg.kind[rd_queue_i][rd_slot_i];
        rd_data_o[DRQ_CHAN_LSB +: DRQ_CHAN_W] =
            st_reg.chan[rd_queue_i][rd_slot_i];
    end

endmodule

// ---- logic/drq_region_access.sv ----
// Purpose: Per-region access masks over shadow channel register windows
// Assumes: APB slave, zero wait states, read data prepared in setup
// Notes:   Completion inputs feed the pending register and interrupts
//
// How it works
// - Each region has 32-bit dma mask, reset zero
// - Mask gates every channel and interrupt register
// - Clear bit: read zero, write ignored
// - Set bit: true read, write takes effect
// - Region completion interrupt uses only masked channels
// - Quick mask bits 7-0 RW, rest zero
// - Clear quick bit: read zero, write ignored
// - Set quick bit: true read, write updates
// - Sixteen read-only entries per queue, two queues
// - Entry kind in bits 7-6
// - Entry channel number in bits 4-0
// - Bit 5 and 31-8 read zero
//
// The APB interface to the registers and the register offsets were decided locally.

`timescale 1ns/1ns

module drq_region_access
    import drq_pkg::*;
#(
    parameter int REGIONS = DRQ_REGIONS
)
(
    // Clock and reset
    input  wire logic                            SYS_CLK_I,
    input  wire logic                            RST_B_I,
    input  wire logic                            CE_I,
    // APB slave
    input  wire logic                            PSEL_I,
    input  wire logic                            PENABLE_I,
    input  wire logic                            PWRITE_I,
    input  wire logic [DRQ_AW-1:0]               PADDR_I,
    input  wire logic [DRQ_DW-1:0]               PWDATA_I,
    input  wire logic [3:0]                      PSTRB_I,
    output logic [DRQ_DW-1:0]                    PRDATA_O,
    output logic                                 PREADY_O,
    output logic                                 PSLVERR_O,
    // Channel completion events
    input  wire logic [DRQ_DMA_CH-1:0]           CH_DONE_I,
    // Queue slot writes
    input  wire logic                            QUE_WR_I,
    input  wire logic                            QUE_SEL_I,
    input  wire logic [3:0]                      QUE_SLOT_I,
    input  wire drq_pkg::drq_kind_t              QUE_KIND_I,
    input  wire logic [DRQ_CHAN_W-1:0]           QUE_CHAN_I,
    // Channel enables to the transfer logic
    output logic [DRQ_DMA_CH-1:0]                CH_EN_O,
    output logic [DRQ_QCK_CH-1:0]                QCK_EN_O,
    // Interrupts
    output logic                                 IRQ_O,
    output logic [REGIONS-1:0]                   REGION_IRQ_O
);

    import drq_pkg::*;

    initial
    begin
        if (REGIONS < 1 || REGIONS > 8)
            $error("drq_region_access: REGIONS must be 1 to 8");
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [REGIONS-1:0][DRQ_DMA_CH-1:0] dma_channel_region_mask;
        logic [REGIONS-1:0][DRQ_QCK_CH-1:0] quick_channel_region_mask;
        logic [DRQ_DMA_CH-1:0]              ch_en;
        logic [DRQ_DMA_CH-1:0]              int_en;
        logic [DRQ_DMA_CH-1:0]              int_pend;
        logic [DRQ_QCK_CH-1:0]              qck_en;
        logic [DRQ_DW-1:0]                  rdata;
        logic                               err;
    } drq_state_t;

    drq_state_t st_reg;
    drq_state_t st_next;

    // ****************************************
    // Address decode
    // ****************************************
    logic                       hit_mask;
    logic                       hit_glb;
    logic                       hit_shd;
    logic                       hit_que;
    logic                       dec_ok;
    logic [2:0]                 mask_rgn;
    logic [2:0]                 shd_rgn;
    logic [2:0]                 win_word;
    logic [DRQ_AW-1:0]          off_mask;
    logic [DRQ_AW-1:0]          off_shd;
    logic [DRQ_AW-1:0]          off_que;
    logic                       que_q;
    logic [3:0]                 que_slot;
    logic [DRQ_DW-1:0]          que_data;

    always_comb
    begin
        off_mask = PADDR_I - DRQ_MASK_BASE;
        off_shd  = PADDR_I - DRQ_SHD_BASE;
        off_que  = PADDR_I - DRQ_QUE_BASE;
        mask_rgn = off_mask[5:3];
        shd_rgn  = off_shd[7:5];
        win_word = PADDR_I[4:2];
        que_q    = off_que[6];
        que_slot = off_que[5:2];
        hit_mask = (PADDR_I < DRQ_GLB_BASE) && (off_mask[11:6] == '0)
                   && (32'(mask_rgn) < REGIONS);
        hit_glb  = (PADDR_I >= DRQ_GLB_BASE)
                   && (PADDR_I < DRQ_GLB_BASE + 12'(4 * DRQ_WIN_WORDS));
        hit_shd  = (PADDR_I >= DRQ_SHD_BASE) && (off_shd[11:8] == '0)
                   && (32'(shd_rgn) < REGIONS)
                   && (32'(win_word) < DRQ_WIN_WORDS);
        hit_que  = (PADDR_I >= DRQ_QUE_BASE) && (PADDR_I < DRQ_QUE_TOP);
        dec_ok   = (PADDR_I[1:0] == 2'h0)
                   && (hit_mask || hit_glb || hit_shd || hit_que);
    end

    // ****************************************
    // Queue view
    // ****************************************
    drq_queue_store #(
        .QUEUES (DRQ_QUEUES),
        .SLOTS  (DRQ_SLOTS)
    ) drq_queue_store_inst (
        .clk_i      (SYS_CLK_I),
        .rst_b_i    (RST_B_I),
        .ce_i       (CE_I),
        .wr_i       (QUE_WR_I),
        .wr_queue_i (QUE_SEL_I),
        .wr_slot_i  (QUE_SLOT_I),
        .wr_kind_i  (QUE_KIND_I),
        .wr_chan_i  (QUE_CHAN_I),
        .rd_queue_i (que_q),
        .rd_slot_i  (que_slot),
        .rd_data_o  (que_data)
    );

    // ****************************************
    // Access gate for the selected window
    // ****************************************
    logic [DRQ_DW-1:0]          gate;
    logic [DRQ_DW-1:0]          bmask;
    logic [DRQ_DW-1:0]          raw;

    always_comb
    begin
        // Global window passes every bit
        gate = '1;
        if (hit_shd)
        begin
            if (win_word == DRQ_W_QCK_EN)
                gate = {24'h000000,
                        st_reg.quick_channel_region_mask[shd_rgn]};
            else
                gate = st_reg.dma_channel_region_mask[shd_rgn];
        end
        for (int b = 0; b < 4; b++)
            bmask[8*b +: 8] = {8{PSTRB_I[b]}};
        case (win_word)
            DRQ_W_CH_EN:    raw = st_reg.ch_en;
            DRQ_W_INT_EN:   raw = st_reg.int_en;
            DRQ_W_INT_PEND: raw = st_reg.int_pend;
            DRQ_W_QCK_EN:   raw = {24'h000000, st_reg.qck_en};
            default:        raw = '0;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    logic                       setup;
    logic                       wr_go;
    logic [DRQ_DW-1:0]          wm;
    logic [DRQ_DW-1:0]          pend_clr;

    always_comb
    begin
        st_next  = st_reg;
        setup    = PSEL_I && !PENABLE_I;
        wr_go    = PSEL_I && PENABLE_I && PWRITE_I && !st_reg.err;
        // Only bits both strobed and permitted by the region change
        wm       = gate & bmask;
        pend_clr = '0;

        // Read data and error are settled in setup so they leave flops
        if (setup)
        begin
            st_next.err   = !dec_ok;
            st_next.rdata = '0;
            // A refused access returns zero whatever window it lands in
            if (!dec_ok)
                st_next.rdata = '0;
            else if (hit_mask)
            begin
                if (off_mask[2])
                    st_next.rdata = {24'h000000,
                        st_reg.quick_channel_region_mask[mask_rgn]};
                else
                    st_next.rdata =
                        st_reg.dma_channel_region_mask[mask_rgn];
            end
            else if (hit_glb || hit_shd)
                st_next.rdata = raw & gate;
            else if (hit_que)
                st_next.rdata = que_data;
        end

        if (wr_go && hit_mask)
        begin
            if (off_mask[2])
                st_next.quick_channel_region_mask[mask_rgn] =
                    PSTRB_I[0] ? PWDATA_I[7:0]
                               : st_reg.quick_channel_region_mask[mask_rgn];
            else
                st_next.dma_channel_region_mask[mask_rgn] =
                    (st_reg.dma_channel_region_mask[mask_rgn] & ~bmask)
                    | (PWDATA_I & bmask);
        end

        // Queue entries ignore writes: they are read-only views
        if (wr_go && (hit_glb || hit_shd))
        begin
            case (win_word)
                DRQ_W_CH_EN:
                    st_next.ch_en = (st_reg.ch_en & ~wm)
                                    | (PWDATA_I & wm);
                DRQ_W_INT_EN:
                    st_next.int_en = (st_reg.int_en & ~wm)
                                     | (PWDATA_I & wm);
                DRQ_W_INT_PEND:
                    pend_clr = PWDATA_I & wm;
                DRQ_W_QCK_EN:
                    st_next.qck_en = (st_reg.qck_en & ~wm[7:0])
                                     | (PWDATA_I[7:0] & wm[7:0]);
                default:
                    pend_clr = '0;
            endcase
        end

        // A completion in the clearing cycle is kept: set beats clear
        st_next.int_pend = (st_reg.int_pend & ~pend_clr) | CH_DONE_I;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            st_reg <= '0;
            for (int m = 0; m < REGIONS; m++)
            begin
                st_reg.dma_channel_region_mask[m]   <= DRQ_DMA_MASK_RST;
                st_reg.quick_channel_region_mask[m] <= DRQ_QCK_MASK_RST;
            end
            st_reg.ch_en    <= DRQ_CH_RST;
            st_reg.int_en   <= DRQ_CH_RST;
            st_reg.int_pend <= DRQ_CH_RST;
        end
        else if (CE_I)
            st_reg <= st_next;
    end

    // ****************************************
    // Outputs
    // ****************************************
    // No wait states; a frozen clock enable also holds the bus
    assign PREADY_O  = PSEL_I && PENABLE_I && CE_I;
    assign PSLVERR_O = PSEL_I && PENABLE_I && st_reg.err;
    assign PRDATA_O  = st_reg.rdata;
    assign CH_EN_O   = st_reg.ch_en;
    assign QCK_EN_O  = st_reg.qck_en;
    assign IRQ_O     = |(st_reg.int_pend & st_reg.int_en);

    genvar g;
    generate
        for (g = 0; g < REGIONS; g++)
        begin : g_rgn_irq
            assign REGION_IRQ_O[g] = |(st_reg.int_pend & st_reg.int_en
                & st_reg.dma_channel_region_mask[g]);
        end
    endgenerate

endmodule

// ---- test/drq_region_access_asserts.sv ----
// Purpose: Port checks for the region access block
// Assumes: Region 0 dma mask mirrored from bus writes
// Notes:   Mirror honours byte strobes
`timescale 1ns/1ns

module drq_region_access_asserts
    import drq_pkg::*;
#(
    parameter int REGIONS = DRQ_REGIONS
)
(
    // Clock and reset
    input wire logic               SYS_CLK_I,
    input wire logic               RST_B_I,
    // APB
    input wire logic               PSEL_I,
    input wire logic               PENABLE_I,
    input wire logic               PWRITE_I,
    input wire logic [11:0]        PADDR_I,
    input wire logic [31:0]        PWDATA_I,
    input wire logic [3:0]         PSTRB_I,
    input wire logic [31:0]        PRDATA_O,
    input wire logic               PREADY_O,
    input wire logic               PSLVERR_O,
    // Channel and interrupt outputs
    input wire logic [31:0]        CH_EN_O,
    input wire logic               IRQ_O,
    input wire logic [REGIONS-1:0] REGION_IRQ_O
);
    // ****************
    // Mirror
    // ****************
    logic [31:0]      mask0_reg;
    logic [31:0]      mask0_next;
    wire logic [31:0] sm = {{8{PSTRB_I[3]}}, {8{PSTRB_I[2]}},
                            {8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};
    wire logic        acc  = PSEL_I & PENABLE_I & PREADY_O;
    wire logic        rd   = acc & ~PWRITE_I;
    wire logic        wr   = acc & PWRITE_I & ~PSLVERR_O;
    wire logic        quea = PADDR_I >= DRQ_QUE_BASE && PADDR_I < DRQ_QUE_TOP;
    wire logic        shd0 = PADDR_I >= DRQ_SHD_BASE &&
                             PADDR_I <= DRQ_SHD_BASE + 12'h008;
    assign mask0_next = (wr && PADDR_I == DRQ_MASK_BASE) ?
        ((mask0_reg & ~sm) | (PWDATA_I & sm)) : mask0_reg;
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            mask0_reg <= DRQ_DMA_MASK_RST;
        else
            mask0_reg <= mask0_next;
    end

    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_B_I);
    AST_MASK_RD: assert property (
        rd && PADDR_I == DRQ_MASK_BASE |-> PRDATA_O == mask0_reg)
        else $error("dma mask read differs");
    AST_QCK_RSVD: assert property (
        rd && PADDR_I[11:8] == 4'h0 && PADDR_I[2:0] == 3'h4
        |-> PRDATA_O[31:8] == 24'h0) else $error("quick mask top bits");
    AST_SHD_GATE: assert property (
        rd && shd0 |-> (PRDATA_O & ~mask0_reg) == 32'h0)
        else $error("shadow read not gated");
    AST_SHD_KEEP: assert property (
        wr && PADDR_I == DRQ_SHD_BASE
        |=> ((CH_EN_O ^ $past(CH_EN_O)) & ~mask0_reg) == 32'h0)
        else $error("shadow write touched masked bit");
    AST_SHD_SET: assert property (
        wr && PADDR_I == DRQ_SHD_BASE && PSTRB_I == 4'hF
        |=> (CH_EN_O & mask0_reg) == ($past(PWDATA_I) & mask0_reg))
        else $error("shadow write lost");
    AST_GLB_WR: assert property (
        wr && PADDR_I == DRQ_GLB_BASE && PSTRB_I == 4'hF
        |=> CH_EN_O == $past(PWDATA_I)) else $error("global write gated");
    AST_QUE_RSVD: assert property (
        rd && quea |-> PRDATA_O[31:8] == 24'h0 && !PRDATA_O[5])
        else $error("queue reserved bits");
    AST_IRQ_SUB: assert property (
        REGION_IRQ_O != '0 |-> IRQ_O) else $error("region irq alone");
    AST_IRQ_OWN: assert property (
        REGION_IRQ_O[0] |-> mask0_reg != 32'h0)
        else $error("region irq with empty mask");
    COV_SHD_WR: cover property (wr && PADDR_I == DRQ_SHD_BASE);
    COV_RIRQ: cover property (REGION_IRQ_O[0]);
    COV_QUE: cover property (rd && quea);
endmodule

bind drq_region_access drq_region_access_asserts #(.REGIONS(REGIONS))
    drq_region_access_asserts_inst (
    .SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CH_EN_O(CH_EN_O),
    .IRQ_O(IRQ_O), .REGION_IRQ_O(REGION_IRQ_O));

// ---- test/drq_region_access_bench.sv ----
// Purpose: Self-checking bench for the region access block
// Assumes: Zero-wait APB; strobes and clock enable varied once each
// Notes:   Queue contents after reset are left unchecked
`timescale 1ns/1ns

module drq_region_access_bench;
    import drq_pkg::*;

    // ****************
    // Signals
    // ****************
    localparam int RG = 4;
    logic          clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic          qwr, qsel, irq, er, clk_en;
    logic [11:0]   paddr, sa;
    logic [31:0]   pwdata, prdata, done, ch_en, rd, d, ce, ie, pd;
    logic [3:0]    qslot, pstrb, strb;
    logic [4:0]    qchan, c;
    logic [7:0]    qck_en, qe;
    logic [RG-1:0] rirq;
    drq_kind_t     qkind;
    logic [31:0]   dm [RG];
    logic [7:0]    qm [RG];
    logic [31:0]   qv [32];
    int            error_cnt, checks_done;

    drq_region_access #(.REGIONS(RG)) drq_region_access_inst (
        .SYS_CLK_I(clk), .RST_B_I(rst_b), .CE_I(clk_en),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .CH_DONE_I(done), .QUE_WR_I(qwr), .QUE_SEL_I(qsel),
        .QUE_SLOT_I(qslot), .QUE_KIND_I(qkind), .QUE_CHAN_I(qchan),
        .CH_EN_O(ch_en), .QCK_EN_O(qck_en), .IRQ_O(irq),
        .REGION_IRQ_O(rirq));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    // ****************
    // Tasks
    // ****************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Idle cycle between transfers keeps one assignment per time step
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] v);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, v};
        pstrb <= strb;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 20)
            chk(32'h1, 32'h0);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic irqchk();
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, |(pd & ie)});
        for (int m = 0; m < RG; m++)
            chk({31'h0, rirq[m]}, {31'h0, |(pd & ie & dm[m])});
    endtask

    function automatic logic [31:0] mrg(input logic [31:0] o, v, m);
        return (o & ~m) | (v & m);
    endfunction

    function automatic logic [31:0] ent(input logic [1:0] k,
                                        input logic [4:0] n);
        return {24'h0, k, 1'b0, n};
    endfunction

    task automatic conclude();
        $display("Checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************
    // Sequence
    // ****************
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pstrb, strb, clk_en} = {4'hF, 4'hF, 1'b1};
        {done, qwr, qsel, qslot, qchan, rst_b} = '0;
        qkind = DRQ_KIND_HW_LATCH;
        {error_cnt, checks_done, ce, ie, pd, qe} = '0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        void'($urandom(32'h543B));
        // Unmapped place refuses and reads zero
        apb(1'b0, 12'h300, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        // Region 1 blocks every dma channel
        for (int m = 0; m < RG; m++)
        begin
            rdchk(12'(8 * m), DRQ_DMA_MASK_RST);
            rdchk(12'(8 * m + 4), 32'h0);
            dm[m] = (m == 1) ? 32'h0 : $urandom();
            d = $urandom();
            qm[m] = d[7:0];
            apb(1'b1, 12'(8 * m), dm[m]);
            apb(1'b1, 12'(8 * m + 4), d);
            rdchk(12'(8 * m), dm[m]);
            rdchk(12'(8 * m + 4), {24'h0, qm[m]});
        end
        // Byte strobes choose which bytes of a mask change
        strb = 4'($urandom());
        d = $urandom();
        apb(1'b1, DRQ_MASK_BASE, d);
        dm[0] = mrg(dm[0], d, {{8{strb[3]}}, {8{strb[2]}},
                               {8{strb[1]}}, {8{strb[0]}}});
        strb = 4'hF;
        rdchk(DRQ_MASK_BASE, dm[0]);
        ce = $urandom();
        qe = 8'($urandom());
        apb(1'b1, DRQ_GLB_BASE, ce);
        apb(1'b1, DRQ_GLB_BASE + 12'hC, {24'h0, qe});
        rdchk(DRQ_GLB_BASE, ce);
        rdchk(DRQ_GLB_BASE + 12'hC, {24'h0, qe});
        // Unaligned access refuses: no data out, no write
        apb(1'b0, DRQ_GLB_BASE + 12'h2, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, DRQ_GLB_BASE + 12'h2, ~ce);
        rdchk(DRQ_GLB_BASE, ce);
        for (int m = 0; m < RG; m++)
        begin
            sa = DRQ_SHD_BASE + 12'(32 * m);
            d = $urandom();
            rdchk(sa, ce & dm[m]);
            rdchk(sa + 12'hC, {24'h0, qe & qm[m]});
            apb(1'b1, sa, d);
            apb(1'b1, sa + 12'hC, d);
            ce = mrg(ce, d, dm[m]);
            qe = 8'(mrg({24'h0, qe}, d, {24'h0, qm[m]}));
            @(negedge clk);
            chk(ch_en, ce);
            chk({24'h0, qck_en}, {24'h0, qe});
        end
        ie = 32'hFFFF_FFFF;
        apb(1'b1, DRQ_GLB_BASE + 12'h4, ie);
        d = $urandom() | dm[0];
        @(posedge clk);
        done <= d;
        @(posedge clk);
        done <= '0;
        pd = d;
        irqchk();
        rdchk(DRQ_SHD_BASE + 12'h8, pd & dm[0]);
        apb(1'b1, DRQ_SHD_BASE + 12'h8, 32'hFFFF_FFFF);
        pd = pd & ~dm[0];
        irqchk();
        rdchk(DRQ_GLB_BASE + 12'h8, pd);
        ie = 32'h0;
        apb(1'b1, DRQ_GLB_BASE + 12'h4, ie);
        irqchk();
        // A low clock enable freezes state, so this completion is lost
        @(posedge clk);
        {clk_en, done} <= {1'b0, 32'hFFFF_FFFF};
        @(posedge clk);
        {clk_en, done} <= {1'b1, 32'h0};
        rdchk(DRQ_GLB_BASE + 12'h8, pd);
        // Every kind code; quick entries keep channels below eight
        for (int i = 0; i < 32; i++)
        begin
            d = $urandom();
            c = (i % 4 == 3) ? {2'h0, d[2:0]} : d[4:0];
            qv[i] = ent(2'(i), c);
            @(posedge clk);
            {qwr, qsel, qslot, qchan} <= {1'b1, 5'(i), c};
            qkind <= drq_kind_t'(2'(i));
        end
        @(posedge clk);
        qwr <= 1'b0;
        apb(1'b1, DRQ_QUE_BASE + 12'h4, 32'hFFFF_FFFF);
        for (int i = 0; i < 32; i++)
            rdchk(DRQ_QUE_BASE + 12'(4 * i), qv[i]);
        conclude();
    end

    initial
    begin
        #100000;
        error_cnt++;
        conclude();
    end
endmodule
